// *** dv/rot_top_bench.sv ***
// self-checking testbench for the rotate instruction datapath
module rot_top_bench
    import rot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk, rst, psel, penable, pwrite, pready, pslverr, mem_we;
    logic [7:0]        paddr, mem_rdata, mem_wdata;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0]        mem [0:4095];
    int                n_errors, comparisons;

    rot_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we));

    // file memory: combinational read, write on the pulse
    assign mem_rdata = mem[mem_addr];
    always @(posedge clk) begin
        if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer, entered just after a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // no limit here: only the watchdog ends a hung access phase
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        chk(n, 32'h1, "pready wait states");
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask : wr32

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp, what);
        chk({31'h0, er}, 32'h0, "pslverr on mapped read");
    endtask : rd_chk

    // run one instruction on operand val at address ea and judge the outcome
    task exec_chk(input logic [5:0] opc, input logic d, input logic a, input logic [7:0] f,
                  input logic [11:0] ea, input logic [7:0] val, input logic [7:0] res,
                  input logic [7:0] st);
        logic [31:0] rd, w0;
        logic        er;
        int          n;
        mem[ea] <= val;
        apb(1'b0, REG_WREG, 32'h0, w0, er);
        wr32(REG_INSTR, {16'h0, opc, d, a, f});
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, rd, er);
            n++;
        end while (rd[ST_BUSY] !== 1'b0 && n < 20);
        chk({24'h0, rd[7:0]}, {24'h0, st}, "flags");
        rd_chk(REG_ADDR, {20'h0, ea}, "resolved address");
        if (d) begin
            chk({24'h0, mem[ea]}, {24'h0, res}, "file written");
            rd_chk(REG_WREG, w0, "working reg kept");
        end else begin
            rd_chk(REG_WREG, {24'h0, res}, "working reg");
            chk({24'h0, mem[ea]}, {24'h0, val}, "file kept");
        end
    endtask : exec_chk

    task t_reset;
        logic [31:0] rd;
        logic        er;
        rd_chk(REG_WREG, 32'h0, "wreg reset");
        rd_chk(REG_STATUS, 32'h0, "status reset");
        rd_chk(REG_BANK, 32'h0, "bank reset");
        rd_chk(REG_CFG, 32'h0, "cfg reset");
        rd_chk(REG_INDEX, 32'h0, "index reset");
        rd_chk(REG_ADDR, 32'h0, "addr reset");
        apb(1'b0, 8'h40, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped read error");
        chk(rd, 32'h0, "unmapped read data");
    endtask : t_reset

    task t_left;
        wr32(REG_BANK, 32'h5);
        wr32(REG_STATUS, 32'h1);
        exec_chk(OPC_RLNC, 1'b0, 1'b0, 8'h70, 12'hf70, 8'hab, 8'h57, 8'h01);
        exec_chk(OPC_RLNC, 1'b1, 1'b1, 8'h12, 12'h512, 8'h80, 8'h01, 8'h01);
        exec_chk(OPC_RLNC, 1'b0, 1'b1, 8'hff, 12'h5ff, 8'h00, 8'h00, 8'h05);
    endtask : t_left

    task t_right;
        exec_chk(OPC_RRC, 1'b1, 1'b1, 8'h34, 12'h534, 8'he6, 8'hf3, 8'h10);
        exec_chk(OPC_RRC, 1'b0, 1'b0, 8'h81, 12'hf81, 8'h01, 8'h00, 8'h05);
        exec_chk(OPC_RRC, 1'b1, 1'b0, 8'h2a, 12'h02a, 8'h55, 8'haa, 8'h11);
    endtask : t_right

    task t_indexed;
        wr32(REG_CFG, 32'h1);
        wr32(REG_INDEX, 32'h200);
        exec_chk(OPC_RLNC, 1'b1, 1'b0, 8'h5f, 12'h25f, 8'h80, 8'h01, 8'h01);
        exec_chk(OPC_RRC, 1'b0, 1'b0, 8'h60, 12'hf60, 8'h02, 8'h81, 8'h10);
        exec_chk(OPC_RLNC, 1'b1, 1'b1, 8'h10, 12'h510, 8'h40, 8'h80, 8'h10);
    endtask : t_indexed

    task t_bad;
        logic [31:0] rd;
        logic        er;
        wr32(REG_INSTR, {16'h0, 6'h3f, 2'b11, 8'h20});
        rd_chk(REG_STATUS, 32'h50, "bad opcode flag");
        rd_chk(REG_ADDR, 32'h510, "nothing executed");
        wr32(REG_STATUS, 32'h40);
        rd_chk(REG_STATUS, 32'h0, "bad flag cleared");
        apb(1'b1, 8'h44, 32'h77, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped write error");
        rd_chk(REG_WREG, 32'h81, "unmapped write ignored");
    endtask : t_bad

    task final_report;
        $display("checks %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        #(20000 * 8);
        n_errors++;
        final_report();
    end

    initial begin
        n_errors = 0;
        comparisons = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_left();
        t_right();
        t_indexed();
        t_bad();
        final_report();
    end
endmodule : rot_top_bench

// *** hdl/rot_alu.sv ***
// rotate unit: left without carry, right through carry
module rot_alu
    import rot_pkg::*;
(
    // operand and result
    rot_alu_if.alu p
);
    always_comb begin
        if (p.is_rrc) begin
            p.result    = {p.carry_in, p.operand[7:1]}; // RULE_02
            p.carry_out = p.operand[0];                 // RULE_02
        end else begin
            p.result    = {p.operand[6:0], p.operand[7]}; // RULE_01
            p.carry_out = p.carry_in;                     // RULE_01
        end
        p.neg  = p.result[7];
        p.zero = (p.result == 8'h00);
    end
endmodule : rot_alu

// *** hdl/rot_alu_if.sv ***
// signals between the core sequencer and the rotate unit
interface rot_alu_if;
    logic       is_rrc;
    logic [7:0] operand;
    logic       carry_in;
    logic [7:0] result;
    logic       carry_out;
    logic       neg;
    logic       zero;
    modport alu  (input is_rrc, operand, carry_in, output result, carry_out, neg, zero);
    modport core (output is_rrc, operand, carry_in, input result, carry_out, neg, zero);
endinterface : rot_alu_if

// *** hdl/rot_pkg.sv ***
// constants and types for the rotate instruction datapath
package rot_pkg;
    localparam int           DATA_W        = 32;
    localparam int           ADDR_W        = 12;
    localparam int           BANK_W        = 4;
    // register byte offsets
    localparam logic [7:0]   REG_INSTR     = 8'h00;
    localparam logic [7:0]   REG_WREG      = 8'h04;
    localparam logic [7:0]   REG_STATUS    = 8'h08;
    localparam logic [7:0]   REG_BANK      = 8'h0c;
    localparam logic [7:0]   REG_CFG       = 8'h10;
    localparam logic [7:0]   REG_INDEX     = 8'h14;
    localparam logic [7:0]   REG_ADDR      = 8'h18;
    // status bit positions
    localparam int           ST_C          = 0;
    localparam int           ST_Z          = 2;
    localparam int           ST_N          = 4;
    localparam int           ST_BAD        = 6;
    localparam int           ST_BUSY       = 7;
    // instruction word fields
    localparam int           OPC_HI        = 15;
    localparam int           OPC_LO        = 10;
    localparam int           D_BIT         = 9;
    localparam int           A_BIT         = 8;
    localparam logic [5:0]   OPC_RLNC      = 6'h11;
    localparam logic [5:0]   OPC_RRC       = 6'h0c;
    // fast bank split and indexed window limit
    localparam logic [7:0]   ACC_SPLIT     = 8'h60;
    localparam logic [7:0]   IDX_LIMIT     = 8'h5f;
    localparam logic [3:0]   ACC_LOW_BANK  = 4'h0;
    localparam logic [3:0]   ACC_HIGH_BANK = 4'hf;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_EXEC  = 3'b010,
        S_WRITE = 3'b100
    } rot_state_e_t;

    typedef struct packed {
        rot_state_e_t         st;
        logic [7:0]           wreg;
        logic                 c;
        logic                 z;
        logic                 n;
        logic                 bad;
        logic [BANK_W-1:0]    bank;
        logic                 ext;
        logic [ADDR_W-1:0]    index_base;
        logic [ADDR_W-1:0]    addr;
        logic                 is_rrc;
        logic                 dest_f;
        logic [7:0]           wdata;
        logic                 we;
    } rot_state_t;
endpackage : rot_pkg

// *** hdl/rot_top.sv ***
// rotate instruction datapath with apb registers and file memory port
// Notes on behaviour
// [RULE_01] left rotate without carry: bit 7 goes to bit 0; only n and z change
// [RULE_02] right rotate through carry: bit 0 into carry, old carry into bit 7
// [RULE_03] destination bit 0 writes the working register, file stays untouched
// [RULE_04] destination bit 1 writes the result back to the source file location
// [RULE_05] access bit 0 maps the address into the fast bank, ignoring bank select
// [RULE_06] access bit 1 joins bank select register with the 8-bit address
// [RULE_07] access 0, extended set on, address up to 5f: indexed literal offset
// [RULE_08] opcode top six bits pick the variant; then d, a, 8-bit address
//
// The implementer's own choices: the register addresses and register access over APB.
module rot_top
    import rot_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // file register memory
    output logic      [ADDR_W-1:0] mem_addr,
    input  wire logic [7:0]        mem_rdata,
    output logic      [7:0]        mem_wdata,
    output logic                   mem_we
);
    rot_state_t r_reg;
    rot_state_t r_next;
    rot_alu_if  ai ();

    logic       apb_wr;
    logic       mapped;
    logic       start;
    logic [5:0] in_opc;
    logic [7:0] in_f;
    logic       in_a;
    logic       in_d;
    logic       opc_ok;
    logic       idx_mode;
    logic [ADDR_W-1:0] res_addr;

    rot_alu u_alu (
        .p (ai.alu)
    );

    assign ai.is_rrc   = r_reg.is_rrc;
    assign ai.operand  = mem_rdata;
    assign ai.carry_in = r_reg.c;

    assign in_opc   = pwdata[OPC_HI:OPC_LO];
    assign in_f     = pwdata[7:0];
    assign in_a     = pwdata[A_BIT];
    assign in_d     = pwdata[D_BIT];
    assign opc_ok   = (in_opc == OPC_RLNC) || (in_opc == OPC_RRC); // RULE_08
    assign idx_mode = !in_a && r_reg.ext && (in_f <= IDX_LIMIT);  // RULE_07
    assign mapped   = (paddr == REG_INSTR) || (paddr == REG_WREG) || (paddr == REG_STATUS)
                   || (paddr == REG_BANK) || (paddr == REG_CFG) || (paddr == REG_INDEX)
                   || (paddr == REG_ADDR);
    assign apb_wr   = psel && penable && pwrite && mapped;
    assign start    = apb_wr && (paddr == REG_INSTR) && (r_reg.st == S_IDLE);

    always_comb begin
        if (idx_mode) begin
            res_addr = r_reg.index_base + ADDR_W'(in_f);   // RULE_07
        end else if (in_a) begin
            res_addr = {r_reg.bank, in_f};                 // RULE_06
        end else if (in_f < ACC_SPLIT) begin
            res_addr = {ACC_LOW_BANK, in_f};               // RULE_05
        end else begin
            res_addr = {ACC_HIGH_BANK, in_f};              // RULE_05
        end
    end

    // apb answers at once; unmapped addresses report an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        prdata = '0;
        case (paddr)
            REG_WREG: begin
                prdata[7:0] = r_reg.wreg;
            end
            REG_STATUS: begin
                prdata[ST_C]    = r_reg.c;
                prdata[ST_Z]    = r_reg.z;
                prdata[ST_N]    = r_reg.n;
                prdata[ST_BAD]  = r_reg.bad;
                prdata[ST_BUSY] = (r_reg.st != S_IDLE);
            end
            REG_BANK: begin
                prdata[BANK_W-1:0] = r_reg.bank;
            end
            REG_CFG: begin
                prdata[0] = r_reg.ext;
            end
            REG_INDEX: begin
                prdata[ADDR_W-1:0] = r_reg.index_base;
            end
            REG_ADDR: begin
                prdata[ADDR_W-1:0] = r_reg.addr;
            end
            default: begin
                prdata = '0;
            end
        endcase
    end

    always_comb begin
        r_next    = r_reg;
        r_next.we = 1'b0;
        // software writes first; the datapath overrides below
        if (apb_wr) begin
            case (paddr)
                REG_WREG: begin
                    r_next.wreg = pwdata[7:0];
                end
                REG_STATUS: begin
                    r_next.c = pwdata[ST_C];
                    r_next.z = pwdata[ST_Z];
                    r_next.n = pwdata[ST_N];
                    if (pwdata[ST_BAD]) begin
                        r_next.bad = 1'b0;
                    end
                end
                REG_BANK: begin
                    r_next.bank = pwdata[BANK_W-1:0];
                end
                REG_CFG: begin
                    r_next.ext = pwdata[0];
                end
                REG_INDEX: begin
                    r_next.index_base = pwdata[ADDR_W-1:0];
                end
                default: begin
                end
            endcase
        end
        case (r_reg.st)
            S_IDLE: begin
                if (start) begin
                    if (opc_ok) begin                           // RULE_08
                        r_next.is_rrc = (in_opc == OPC_RRC);    // RULE_08
                        r_next.dest_f = in_d;
                        r_next.addr   = res_addr;
                        r_next.st     = S_EXEC;
                    end else begin
                        r_next.bad = 1'b1;
                    end
                end
            end
            S_EXEC: begin
                r_next.n = ai.neg;
                r_next.z = ai.zero;
                r_next.c = ai.carry_out;                        // RULE_01 RULE_02
                if (r_reg.dest_f) begin
                    r_next.wdata = ai.result;                   // RULE_04
                    r_next.we    = 1'b1;                        // RULE_04
                    r_next.st    = S_WRITE;
                end else begin
                    r_next.wreg = ai.result;                    // RULE_03
                    r_next.st   = S_IDLE;
                end
            end
            S_WRITE: begin
                r_next.st = S_IDLE;
            end
            default: begin
                r_next.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg    <= '0;
            r_reg.st <= S_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign mem_addr  = r_reg.addr;
    assign mem_wdata = r_reg.wdata;
    assign mem_we    = r_reg.we;

    a_rlnc_rotate: assert property (@(posedge clk) disable iff (rst) // RULE_01
        (r_reg.st == S_EXEC && !r_reg.is_rrc) |->
        (ai.result == {mem_rdata[6:0], mem_rdata[7]}) ##1 (r_reg.c == $past(r_reg.c)))
        else $error("left rotate result or carry wrong");
    a_rrc_carry: assert property (@(posedge clk) disable iff (rst) // RULE_02
        (r_reg.st == S_EXEC && r_reg.is_rrc) |->
        (ai.result == {r_reg.c, mem_rdata[7:1]}) ##1 (r_reg.c == $past(mem_rdata[0])))
        else $error("right rotate through carry wrong");
    a_flags_nz: assert property (@(posedge clk) disable iff (rst) // RULE_01
        (r_reg.st == S_EXEC) |=>
        (r_reg.z == ($past(ai.result) == 8'h00)) && (r_reg.n == $past(ai.result[7])))
        else $error("n or z flag wrong");
    a_dest_wreg: assert property (@(posedge clk) disable iff (rst) // RULE_03
        (r_reg.st == S_EXEC && !r_reg.dest_f) |=>
        (r_reg.wreg == $past(ai.result)) && !mem_we && (r_reg.st == S_IDLE))
        else $error("working register destination wrong");
    a_dest_file: assert property (@(posedge clk) disable iff (rst) // RULE_04
        (r_reg.st == S_EXEC && r_reg.dest_f) |=>
        mem_we && (mem_wdata == $past(ai.result)) && (mem_addr == $past(mem_addr)) ##1 !mem_we)
        else $error("file write-back wrong");
    a_access_bank: assert property (@(posedge clk) disable iff (rst) // RULE_05
        (start && opc_ok && !in_a && !idx_mode) |=>
        (r_reg.addr[7:0] == $past(in_f)) && (r_reg.addr[ADDR_W-1:8] ==
         (($past(in_f) < ACC_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK)))
        else $error("fast bank address wrong");
    a_bank_select: assert property (@(posedge clk) disable iff (rst) // RULE_06
        (start && opc_ok && in_a) |=> (r_reg.addr == {$past(r_reg.bank), $past(in_f)}))
        else $error("banked address wrong");
    a_indexed_mode: assert property (@(posedge clk) disable iff (rst) // RULE_07
        (start && opc_ok && idx_mode) |=>
        (r_reg.addr == ADDR_W'($past(r_reg.index_base) + ADDR_W'($past(in_f)))))
        else $error("indexed offset address wrong");
    a_decode_reject: assert property (@(posedge clk) disable iff (rst) // RULE_08
        (start && !opc_ok) |=> (r_reg.st == S_IDLE) && r_reg.bad && !mem_we)
        else $error("unknown opcode not rejected");

    c_rlnc_wreg: cover property (@(posedge clk) disable iff (rst)
        r_reg.st == S_EXEC && !r_reg.is_rrc && !r_reg.dest_f);
    c_rrc_file: cover property (@(posedge clk) disable iff (rst)
        r_reg.st == S_EXEC && r_reg.is_rrc && r_reg.dest_f);
    c_indexed: cover property (@(posedge clk) disable iff (rst) start && opc_ok && idx_mode);
    c_bad_op: cover property (@(posedge clk) disable iff (rst) start && !opc_ok);
endmodule : rot_top
